// ==== common/pbf_regs.vh ====
// constants for the packet bus fabric and its sram target
`ifndef PBF_REGS_VH
`define PBF_REGS_VH
`define PBF_SYS_DW 128
`define PBF_PER_DW 32
`define PBF_PA_W 48
`define PBF_DEV_W 8
`define PBF_NODE_W 8
`define PBF_GEO_W 16
`define PBF_SYS_MAX_BEATS 8
`define PBF_LEN_W 4
`define PBF_SRAM_WORDS 8192
`define PBF_SRAM_AW 13
`define PBF_FIFO_DEPTH 16
`define PBF_NODE_SRAM 8'h01
`define PBF_NODE_DRAM 8'h02
`define PBF_NODE_REGS 8'h03
`define PBF_NODE_BRIDGE0 8'h04
`define PBF_NODE_BRIDGE1 8'h05
`define PBF_LOCAL_OFS_W 32
`define PBF_APER_SEL_W 4
`define PBF_RSP_OK 2'h0
`define PBF_RSP_ERR 2'h1
`endif

// ==== verilog/pbf_fifo.v ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pbf_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  reg [AW:0] cnt_next;
  reg in_ready_reg;
  wire push;
  wire pop;
  // ready comes from a flop so the port is registered; it looks at the next count
  assign in_ready = in_ready_reg;
  assign out_valid = (cnt_reg != 0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @* begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      in_ready_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      in_ready_reg <= (cnt_next != DEPTH);
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/pbf_fabric.v ====
// packet bus fabric: system channel router, peripheral channel, on-chip sram target
// Overview of operation
// - two independent channels, system and peripheral
// - peripheral channel carries registers and interrupt messages
// - pipelined split transactions, many requests outstanding
// - system channel runs on core clock
// - system data 128 bits, 128 bytes max
// - peripheral data 32 bits, 4 bytes each
// - targets reached by 48-bit physical address
// - device id at boot, fixed node ids
// - device and node id form geographic address
// - aperture maps logical to physical address
// - bridge ports extend network with same addressing
// - sram holds 8K words of 16 bytes
// - sram sustains one word per cycle
// - mixed reads and writes need no idle
// - sram serves any bus master
// - dram controller is another system target
`timescale 1ns/1ns
`default_nettype none
`include "pbf_regs.vh"
module pbf_fabric #(
  parameter SRAM_AW = `PBF_SRAM_AW,
  parameter FIFO_DEPTH = `PBF_FIFO_DEPTH
) (
  // the one clock is the core clock
  input wire clk_sys,
  input wire arst_n,
  input wire [`PBF_DEV_W-1:0] boot_dev_id,
  input wire boot_dev_id_load,
  input wire [`PBF_APER_SEL_W-1:0] aper_wr_idx,
  input wire aper_wr_en,
  input wire [`PBF_PA_W-1:0] aper_wr_base,
  input wire sys_req_valid,
  output wire sys_req_ready,
  input wire sys_req_write,
  input wire [`PBF_GEO_W-1:0] sys_req_src,
  input wire [`PBF_PA_W-1:0] sys_req_laddr,
  input wire [`PBF_LEN_W-1:0] sys_req_beat,
  input wire sys_req_last,
  input wire [`PBF_SYS_DW-1:0] sys_req_data,
  output reg sys_rsp_valid,
  output reg [`PBF_GEO_W-1:0] sys_rsp_dst,
  output reg [1:0] sys_rsp_status,
  output reg sys_rsp_last,
  output reg [`PBF_SYS_DW-1:0] sys_rsp_data,
  output reg dram_req_valid,
  output reg dram_req_write,
  output reg [`PBF_GEO_W-1:0] dram_req_src,
  output reg [`PBF_LOCAL_OFS_W-1:0] dram_req_addr,
  output reg [`PBF_SYS_DW-1:0] dram_req_data,
  input wire dram_rsp_valid,
  input wire [`PBF_GEO_W-1:0] dram_rsp_dst,
  input wire [`PBF_SYS_DW-1:0] dram_rsp_data,
  output reg bridge_req_valid,
  output reg bridge_req_port,
  output reg bridge_req_write,
  output reg [`PBF_GEO_W-1:0] bridge_req_src,
  output reg [`PBF_PA_W-1:0] bridge_req_paddr,
  output reg [`PBF_SYS_DW-1:0] bridge_req_data,
  input wire per_req_valid,
  input wire per_req_write,
  input wire per_req_irq,
  input wire [`PBF_GEO_W-1:0] per_req_src,
  input wire [`PBF_PA_W-1:0] per_req_paddr,
  input wire [`PBF_PER_DW-1:0] per_req_data,
  output reg per_out_valid,
  output reg per_out_write,
  output reg per_out_irq,
  output reg [`PBF_GEO_W-1:0] per_out_src,
  output reg [`PBF_LOCAL_OFS_W-1:0] per_out_addr,
  output reg [`PBF_PER_DW-1:0] per_out_data,
  output reg per_err_valid,
  output reg [`PBF_GEO_W-1:0] per_err_dst,
  output reg [`PBF_DEV_W-1:0] dev_id_out
);
  localparam RW = 1 + `PBF_GEO_W + `PBF_PA_W + 1 + `PBF_SYS_DW;
  localparam NAPER = 16;
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  // device id caught after reset, node ids are constants
  reg [`PBF_DEV_W-1:0] dev_id_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dev_id_reg <= {`PBF_DEV_W{1'b0}};
      dev_id_out <= {`PBF_DEV_W{1'b0}};
    end else begin
      if (boot_dev_id_load) begin
        dev_id_reg <= boot_dev_id;
        dev_id_out <= boot_dev_id;
      end
    end
  end

  // aperture table, selected by top logical address bits
  reg [`PBF_PA_W-1:0] aper_reg [0:NAPER-1];
  integer i;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < NAPER; i = i + 1) begin
        aper_reg[i] <= {`PBF_PA_W{1'b0}};
      end
    end else if (aper_wr_en) begin
      aper_reg[aper_wr_idx] <= aper_wr_base;
    end
  end

  // fifo decouples masters so requests keep flowing
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [RW-1:0] fifo_out_data;
  wire [`PBF_PA_W-1:0] mapped_paddr;
  wire [`PBF_APER_SEL_W-1:0] aper_sel;
  assign aper_sel = sys_req_laddr[`PBF_PA_W-1:`PBF_PA_W-`PBF_APER_SEL_W];
  // 48-bit physical address = aperture base plus offset
  assign mapped_paddr = aper_reg[aper_sel] +
    {{(`PBF_PA_W-`PBF_LOCAL_OFS_W){1'b0}}, sys_req_laddr[`PBF_LOCAL_OFS_W-1:0]};
  pbf_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_req_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(sys_req_valid),
    .in_ready(sys_req_ready),
    .in_data({sys_req_write, sys_req_src, mapped_paddr, sys_req_last, sys_req_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  wire f_write;
  wire [`PBF_GEO_W-1:0] f_src;
  wire [`PBF_PA_W-1:0] f_paddr;
  wire f_last;
  wire [`PBF_SYS_DW-1:0] f_data;
  assign {f_write, f_src, f_paddr, f_last, f_data} = fifo_out_data;

  // geographic address = device id then node id
  wire [`PBF_DEV_W-1:0] f_dev;
  wire [`PBF_NODE_W-1:0] f_node;
  assign f_dev = f_paddr[`PBF_PA_W-1:`PBF_PA_W-`PBF_DEV_W];
  assign f_node = f_paddr[`PBF_PA_W-`PBF_DEV_W-1:`PBF_PA_W-`PBF_GEO_W];
  wire is_local;
  assign is_local = (f_dev == dev_id_reg);
  wire hit_sram;
  wire hit_dram;
  wire hit_bridge;
  assign hit_sram = is_local && (f_node == `PBF_NODE_SRAM);
  assign hit_dram = is_local && (f_node == `PBF_NODE_DRAM);
  // foreign device ids leave by a bridge port
  assign hit_bridge = !is_local;

  // sram pipeline: one request per cycle, never stalls
  assign fifo_out_ready = 1'b1;
  wire go;
  assign go = fifo_out_valid;
  wire [SRAM_AW-1:0] sram_idx;
  assign sram_idx = f_paddr[SRAM_AW+3:4];
  reg [`PBF_SYS_DW-1:0] sram_mem [0:(1<<SRAM_AW)-1];
  reg [`PBF_SYS_DW-1:0] sram_rd_reg;
  // one access per cycle, any address
  // read and write share no turnaround
  always @(posedge clk_sys) begin
    if (go && hit_sram) begin
      if (f_write) begin
        sram_mem[sram_idx] <= f_data;
      end
      sram_rd_reg <= sram_mem[sram_idx];
    end
  end
  reg s1_valid_reg;
  reg s1_err_reg;
  reg s1_write_reg;
  reg s1_last_reg;
  reg [`PBF_GEO_W-1:0] s1_src_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_valid_reg <= 1'b0;
      s1_err_reg <= 1'b0;
      s1_write_reg <= 1'b0;
      s1_last_reg <= 1'b0;
      s1_src_reg <= {`PBF_GEO_W{1'b0}};
    end else begin
      s1_valid_reg <= go && (hit_sram || !(hit_dram || hit_bridge));
      s1_err_reg <= !(hit_sram || hit_dram || hit_bridge);
      s1_write_reg <= f_write;
      s1_last_reg <= f_last;
      s1_src_reg <= f_src;
    end
  end

  // dram controller is a plain downstream target
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dram_req_valid <= 1'b0;
      dram_req_write <= 1'b0;
      dram_req_src <= {`PBF_GEO_W{1'b0}};
      dram_req_addr <= {`PBF_LOCAL_OFS_W{1'b0}};
      dram_req_data <= {`PBF_SYS_DW{1'b0}};
      bridge_req_valid <= 1'b0;
      bridge_req_port <= 1'b0;
      bridge_req_write <= 1'b0;
      bridge_req_src <= {`PBF_GEO_W{1'b0}};
      bridge_req_paddr <= {`PBF_PA_W{1'b0}};
      bridge_req_data <= {`PBF_SYS_DW{1'b0}};
    end else begin
      dram_req_valid <= go && hit_dram;
      dram_req_write <= f_write;
      dram_req_src <= f_src;
      dram_req_addr <= f_paddr[`PBF_LOCAL_OFS_W-1:0];
      dram_req_data <= f_data;
      // same 48-bit address carried off chip
      bridge_req_valid <= go && hit_bridge;
      bridge_req_port <= (f_dev > dev_id_reg);
      bridge_req_write <= f_write;
      bridge_req_src <= f_src;
      bridge_req_paddr <= f_paddr;
      bridge_req_data <= f_data;
    end
  end

  // response merge: sram/error pipeline wins, dram answer held until a cycle with no pipeline response
  reg dram_hold_reg;
  reg [`PBF_GEO_W-1:0] dram_hold_dst_reg;
  reg [`PBF_SYS_DW-1:0] dram_hold_data_reg;
  wire pipe_rsp;
  assign pipe_rsp = s1_valid_reg && (!s1_write_reg || s1_last_reg || s1_err_reg);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sys_rsp_valid <= 1'b0;
      sys_rsp_dst <= {`PBF_GEO_W{1'b0}};
      sys_rsp_status <= `PBF_RSP_OK;
      sys_rsp_last <= 1'b0;
      sys_rsp_data <= {`PBF_SYS_DW{1'b0}};
      dram_hold_reg <= ST_IDLE;
      dram_hold_dst_reg <= {`PBF_GEO_W{1'b0}};
      dram_hold_data_reg <= {`PBF_SYS_DW{1'b0}};
    end else begin
      if (dram_rsp_valid) begin
        dram_hold_reg <= ST_HOLD;
        dram_hold_dst_reg <= dram_rsp_dst;
        dram_hold_data_reg <= dram_rsp_data;
      end else if (!pipe_rsp) begin
        dram_hold_reg <= ST_IDLE;
      end
      if (pipe_rsp) begin
        sys_rsp_valid <= 1'b1;
        // answer goes back to the requester
        sys_rsp_dst <= s1_src_reg;
        sys_rsp_status <= s1_err_reg ? `PBF_RSP_ERR : `PBF_RSP_OK;
        sys_rsp_last <= 1'b1;
        sys_rsp_data <= s1_write_reg ? {`PBF_SYS_DW{1'b0}} : sram_rd_reg;
      end else if (dram_hold_reg == ST_HOLD) begin
        sys_rsp_valid <= 1'b1;
        sys_rsp_dst <= dram_hold_dst_reg;
        sys_rsp_status <= `PBF_RSP_OK;
        sys_rsp_last <= 1'b1;
        sys_rsp_data <= dram_hold_data_reg;
      end else begin
        sys_rsp_valid <= 1'b0;
        sys_rsp_last <= 1'b0;
      end
    end
  end

  // peripheral channel has its own path, sharing only the device id register
  // register access and interrupt message pass here
  wire per_local;
  assign per_local = per_req_paddr[`PBF_PA_W-1:`PBF_PA_W-`PBF_DEV_W] == dev_id_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      per_out_valid <= 1'b0;
      per_out_write <= 1'b0;
      per_out_irq <= 1'b0;
      per_out_src <= {`PBF_GEO_W{1'b0}};
      per_out_addr <= {`PBF_LOCAL_OFS_W{1'b0}};
      per_out_data <= {`PBF_PER_DW{1'b0}};
      per_err_valid <= 1'b0;
      per_err_dst <= {`PBF_GEO_W{1'b0}};
    end else begin
      per_out_valid <= per_req_valid && per_local;
      per_out_write <= per_req_write;
      per_out_irq <= per_req_irq;
      per_out_src <= per_req_src;
      per_out_addr <= per_req_paddr[`PBF_LOCAL_OFS_W-1:0];
      per_out_data <= per_req_data;
      per_err_valid <= per_req_valid && !per_local;
      per_err_dst <= per_req_src;
    end
  end
endmodule
`default_nettype wire

// ==== test/pbf_fabric_props.sv ====
// concurrent checks on the fabric ports
`timescale 1ns/1ns
`default_nettype none
module pbf_fabric_props #(
  parameter SRAM_AW = 13,
  parameter FIFO_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] boot_dev_id,
  input wire logic boot_dev_id_load,
  input wire logic [7:0] dev_id_out,
  input wire logic per_req_valid,
  input wire logic [15:0] per_req_src,
  input wire logic [47:0] per_req_paddr,
  input wire logic [31:0] per_req_data,
  input wire logic per_req_write,
  input wire logic per_req_irq,
  input wire logic per_out_valid,
  input wire logic per_out_write,
  input wire logic per_out_irq,
  input wire logic [15:0] per_out_src,
  input wire logic [31:0] per_out_addr,
  input wire logic [31:0] per_out_data,
  input wire logic per_err_valid,
  input wire logic [15:0] per_err_dst,
  input wire logic dram_req_valid,
  input wire logic bridge_req_valid,
  input wire logic sys_rsp_valid,
  input wire logic [1:0] sys_rsp_status
);
  logic [31:0] ofs_reg;
  always_ff @(posedge clk_sys) ofs_reg <= per_req_paddr[31:0];
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_local;
    per_req_valid && per_req_paddr[47:40] == dev_id_out;
  endsequence
  sequence s_remote;
    per_req_valid && per_req_paddr[47:40] != dev_id_out;
  endsequence
  a_per_deliver: assert property (s_local |=> per_out_valid && !per_err_valid)
    else $error("home word not delivered");
  a_per_word: assert property (s_local |=>
    per_out_data == $past(per_req_data) && per_out_addr == ofs_reg) else $error("word altered");
  a_per_kind: assert property (s_local |=>
    per_out_write == $past(per_req_write) && per_out_irq == $past(per_req_irq) &&
    per_out_src == $past(per_req_src)) else $error("kind altered");
  a_per_remote: assert property (s_remote |=>
    per_err_valid && !per_out_valid && per_err_dst == $past(per_req_src)) else $error("bad refusal");
  a_per_cause: assert property ((per_out_valid || per_err_valid) |-> $past(per_req_valid))
    else $error("spurious peripheral output");
  a_id_load: assert property (boot_dev_id_load |=> dev_id_out == $past(boot_dev_id))
    else $error("device id not loaded");
  a_id_hold: assert property (!boot_dev_id_load |=> $stable(dev_id_out))
    else $error("device id drifted");
  a_one_target: assert property (!(dram_req_valid && bridge_req_valid))
    else $error("beat sent to two targets");
  a_rsp_code: assert property (sys_rsp_valid |-> sys_rsp_status <= 2'h1)
    else $error("unknown status code");
endmodule
bind pbf_fabric pbf_fabric_props #(.SRAM_AW(SRAM_AW), .FIFO_DEPTH(FIFO_DEPTH)) i_props (
  .clk_sys(clk_sys), .arst_n(arst_n), .boot_dev_id(boot_dev_id),
  .boot_dev_id_load(boot_dev_id_load), .dev_id_out(dev_id_out),
  .per_req_valid(per_req_valid), .per_req_src(per_req_src), .per_req_paddr(per_req_paddr),
  .per_req_data(per_req_data), .per_req_write(per_req_write), .per_req_irq(per_req_irq),
  .per_out_valid(per_out_valid), .per_out_write(per_out_write), .per_out_irq(per_out_irq),
  .per_out_src(per_out_src), .per_out_addr(per_out_addr), .per_out_data(per_out_data),
  .per_err_valid(per_err_valid), .per_err_dst(per_err_dst),
  .dram_req_valid(dram_req_valid), .bridge_req_valid(bridge_req_valid),
  .sys_rsp_valid(sys_rsp_valid), .sys_rsp_status(sys_rsp_status));
`default_nettype wire

// ==== test/pbf_dram_model.sv ====
// dram target model: answers reads in order after a short or long delay
`timescale 1ns/1ns
`default_nettype none
module pbf_dram_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic dram_req_valid,
  input wire logic dram_req_write,
  input wire logic [15:0] dram_req_src,
  input wire logic [31:0] dram_req_addr,
  output logic dram_rsp_valid = 1'b0,
  output logic [15:0] dram_rsp_dst = 16'h0,
  output logic [127:0] dram_rsp_data = 128'h0
);
  logic [47:0] pend[$];
  logic [47:0] e;
  int wait_n = 0;
  always @(posedge clk_sys) begin
    if (dram_req_valid === 1'b1 && dram_req_write === 1'b0)
      pend.push_back({dram_req_src, dram_req_addr});
    if (dram_rsp_valid) begin
      // released lines flip so a stale value never passes
      dram_rsp_valid <= 1'b0;
      dram_rsp_dst <= ~dram_rsp_dst;
      dram_rsp_data <= ~dram_rsp_data;
    end else if (pend.size() > 0 && wait_n < (slow ? 5 : 1)) begin
      wait_n <= wait_n + 1;
    end else if (pend.size() > 0) begin
      e = pend.pop_front();
      wait_n <= 0;
      dram_rsp_valid <= 1'b1;
      dram_rsp_dst <= e[47:32];
      dram_rsp_data <= {4{e[31:0]}};
    end
  end
endmodule
`default_nettype wire

// ==== test/test_packet_bus_fabric_sram.sv ====
// self-checking bench for the packet bus fabric
`timescale 1ns/1ns
`default_nettype none
module test_packet_bus_fabric_sram;
  logic clk_sys = 1'b0, arst_n = 1'b0, boot_dev_id_load = 1'b0, aper_wr_en = 1'b0, slow = 1'b0;
  logic sys_req_valid = 1'b0, sys_req_write = 1'b0, sys_req_last = 1'b0, per_req_valid = 1'b0;
  logic per_req_write = 1'b0, per_req_irq = 1'b0, sys_req_ready, sys_rsp_valid, sys_rsp_last, w;
  logic dram_req_valid, dram_req_write, dram_rsp_valid, bridge_req_valid, bridge_req_port;
  logic bridge_req_write, per_out_valid, per_out_write, per_out_irq, per_err_valid;
  logic [1:0] sys_rsp_status;
  logic [3:0] aper_wr_idx = 4'h0, sys_req_beat = 4'h0;
  logic [7:0] boot_dev_id = 8'h00, dev_id_out, d;
  logic [12:0] wa[8], k;
  logic [15:0] sys_req_src = 16'h0, per_req_src = 16'h0, s;
  logic [15:0] sys_rsp_dst, dram_req_src, dram_rsp_dst, bridge_req_src, per_out_src, per_err_dst;
  logic [31:0] per_req_data = 32'h0, dram_req_addr, per_out_addr, per_out_data, a;
  logic [47:0] aper_wr_base = 48'h0, sys_req_laddr = 48'h0, per_req_paddr = 48'h0;
  logic [47:0] bridge_req_paddr;
  logic [127:0] sys_req_data = 128'h0, sys_rsp_data, dram_req_data, dram_rsp_data, v;
  logic [127:0] bridge_req_data;
  logic [127:0] sh[logic [12:0]];
  logic [147:0] rq[$];
  logic [193:0] bq[$];
  int err_total = 0, samples_checked = 0, cyc = 0, stalls = 0;
  pbf_fabric #(.SRAM_AW(13), .FIFO_DEPTH(16)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .boot_dev_id(boot_dev_id),
    .boot_dev_id_load(boot_dev_id_load), .aper_wr_idx(aper_wr_idx),
    .aper_wr_en(aper_wr_en), .aper_wr_base(aper_wr_base),
    .sys_req_valid(sys_req_valid), .sys_req_ready(sys_req_ready),
    .sys_req_write(sys_req_write), .sys_req_src(sys_req_src),
    .sys_req_laddr(sys_req_laddr), .sys_req_beat(sys_req_beat),
    .sys_req_last(sys_req_last), .sys_req_data(sys_req_data),
    .sys_rsp_valid(sys_rsp_valid), .sys_rsp_dst(sys_rsp_dst),
    .sys_rsp_status(sys_rsp_status), .sys_rsp_last(sys_rsp_last),
    .sys_rsp_data(sys_rsp_data), .dram_req_valid(dram_req_valid),
    .dram_req_write(dram_req_write), .dram_req_src(dram_req_src),
    .dram_req_addr(dram_req_addr), .dram_req_data(dram_req_data),
    .dram_rsp_valid(dram_rsp_valid), .dram_rsp_dst(dram_rsp_dst),
    .dram_rsp_data(dram_rsp_data), .bridge_req_valid(bridge_req_valid),
    .bridge_req_port(bridge_req_port), .bridge_req_write(bridge_req_write),
    .bridge_req_src(bridge_req_src), .bridge_req_paddr(bridge_req_paddr),
    .bridge_req_data(bridge_req_data), .per_req_valid(per_req_valid),
    .per_req_write(per_req_write), .per_req_irq(per_req_irq),
    .per_req_src(per_req_src), .per_req_paddr(per_req_paddr),
    .per_req_data(per_req_data), .per_out_valid(per_out_valid),
    .per_out_write(per_out_write), .per_out_irq(per_out_irq),
    .per_out_src(per_out_src), .per_out_addr(per_out_addr),
    .per_out_data(per_out_data), .per_err_valid(per_err_valid),
    .per_err_dst(per_err_dst), .dev_id_out(dev_id_out));
  pbf_dram_model i_dram (
    .clk_sys(clk_sys), .slow(slow), .dram_req_valid(dram_req_valid),
    .dram_req_write(dram_req_write), .dram_req_src(dram_req_src),
    .dram_req_addr(dram_req_addr), .dram_rsp_valid(dram_rsp_valid),
    .dram_rsp_dst(dram_rsp_dst), .dram_rsp_data(dram_rsp_data));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_rsp(input logic [147:0] got, input logic [147:0] exp);
    samples_checked++;
    if (got[147:129] !== exp[147:129] || (exp[128] && got[127:0] !== exp[127:0])) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [193:0] got, input logic [193:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic exp_rsp(input logic [1:0] st, input logic c, input logic [127:0] dt);
    rq.push_back({s, st, 1'b1, c, dt});
  endtask
  // request held until the edge that samples ready
  task automatic sys(input logic wr, input logic [47:0] la, input logic l, input logic [127:0] dt);
    sys_req_valid = 1'b1;
    sys_req_write = wr;
    sys_req_src = s;
    sys_req_laddr = la;
    sys_req_last = l;
    sys_req_data = dt;
    @(posedge clk_sys);
    while (sys_req_ready !== 1'b1) begin
      stalls++;
      @(posedge clk_sys);
    end
    #1;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sys_rsp_valid === 1'b1)
      cmp_rsp({sys_rsp_dst, sys_rsp_status, sys_rsp_last, 1'b1, sys_rsp_data},
        rq.size() ? rq.pop_front() : 'x);
    if (bridge_req_valid === 1'b1)
      cmp_val({bridge_req_write, bridge_req_port, bridge_req_src, bridge_req_paddr,
        bridge_req_data}, bq.size() ? bq.pop_front() : 'x);
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    a = $urandom(78);
    repeat (20) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    d = 8'h40 | 8'($urandom & 15);
    boot_dev_id = d;
    boot_dev_id_load = 1'b1;
    tick();
    boot_dev_id_load = 1'b0;
    // entries: sram, dram, empty node, lower chip, higher chip
    aper_wr_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      aper_wr_idx = 4'(i);
      aper_wr_base = {i == 3 ? d - 8'h01 : i == 4 ? d + 8'h01 : d,
        i == 1 ? 8'h02 : i == 2 ? 8'h07 : 8'h01, 32'h0};
      tick();
    end
    aper_wr_en = 1'b0;
    for (int i = 0; i < 8; i++) wa[i] = i == 0 ? 13'h1FFF : 13'($urandom);
    // writes back to back, then reads and writes mixed
    for (int i = 0; i < 24; i++) begin
      w = i < 8 || i % 2 == 1;
      k = wa[w ? i % 8 : (i + 3) % 8];
      v = {$urandom, $urandom, $urandom, $urandom};
      s = 16'($urandom);
      if (w) sh[k] = v;
      exp_rsp(2'h0, !w, sh[k]);
      sys(w, {31'h0, k, 4'h0}, 1'b1, v);
    end
    cmp_val(194'(stalls), 194'h0);
    // eight 16-byte beats answered once, then read back
    for (int i = 0; i < 16; i++) begin
      k = 13'h0100 + 13'(i % 8);
      v = {4{$urandom}};
      sys_req_beat = 4'(i % 8);
      if (i < 8) sh[k] = v;
      if (i >= 7) exp_rsp(2'h0, i > 7, sh[k]);
      sys(i < 8, {31'h0, k, 4'h0}, i >= 7, v);
    end
    for (int i = 0; i < 2; i++) begin
      s = 16'($urandom);
      exp_rsp(2'h1, 1'b0, 128'h0);
      sys(i[0], {16'h2000, $urandom}, 1'b1, v);
    end
    sys_req_valid = 1'b0;
    repeat (10) tick();
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      s = 16'($urandom);
      a = $urandom & 32'hFFFFFFF0;
      exp_rsp(2'h0, 1'b1, {4{a}});
      sys(1'b0, {16'h1000, a}, 1'b1, v);
      sys_req_valid = 1'b0;
      repeat (10) tick();
    end
    // lower chip on port 0, higher on port 1
    for (int i = 3; i < 5; i++) begin
      a = $urandom;
      bq.push_back({1'b1, i == 4, s, i == 3 ? d - 8'h01 : d + 8'h01, 8'h01, a, v});
      sys(1'b1, {4'(i), 12'h0, a}, 1'b1, v);
    end
    sys_req_valid = 1'b0;
    // register words and interrupt messages, home and remote
    for (int i = 0; i < 8; i++) begin
      per_req_valid = 1'b1;
      per_req_write = i[0];
      per_req_irq = i[1];
      per_req_src = 16'($urandom);
      per_req_data = $urandom;
      per_req_paddr = {i < 6 ? d : d + 8'h01, 8'h03, $urandom};
      tick();
    end
    per_req_valid = 1'b0;
    repeat (20) tick();
    cmp_val(194'(rq.size() + bq.size()), 194'h0);
    finish_test();
  end
endmodule
`default_nettype wire
